// ### smsc_pkg.sv
package smsc_pkg;

  // system clock and default serial rate
  localparam int unsigned SYS_CLK_HZ      = 40_000_000;
  localparam int unsigned SCLK_HZ_DEFAULT = 20_000_000;

  // structural limits
  localparam int unsigned DATA_W_MAX = 16;
  localparam int unsigned SEL_W      = 16;
  localparam int unsigned ADDR_W     = 5;
  localparam int unsigned CNT_W      = 6;
  localparam int unsigned DIV_W      = 16;

  // register byte offsets
  localparam logic [4:0] ADDR_RXDATA  = 5'h00;
  localparam logic [4:0] ADDR_TXDATA  = 5'h04;
  localparam logic [4:0] ADDR_STATUS  = 5'h08;
  localparam logic [4:0] ADDR_CONTROL = 5'h0C;
  localparam logic [4:0] ADDR_SELECT  = 5'h10;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control register, bit 0 upward: rx irq enable, tx irq enable, flow control
  typedef struct packed {
    logic flow_en;
    logic irq_tx_en;
    logic irq_rx_en;
  } smsc_ctrl_t;

  // status register, bit 0 upward
  typedef struct packed {
    logic overrun;
    logic busy;
    logic tmt;
    logic trdy;
    logic rrdy;
  } smsc_status_t;

  localparam smsc_ctrl_t  CTRL_RESET   = 3'h0;
  localparam logic [15:0] SELECT_RESET = 16'h0000;

  // one-hot master sequencer states
  typedef enum logic [1:0] {
    MS_IDLE = 2'b01,
    MS_RUN  = 2'b10
  } smsc_mstate_t;

endpackage : smsc_pkg

// ### smsc_sync.sv
module smsc_sync #(
  parameter int unsigned W = 1
) (
  // clock and control
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= '0;
      q      <= '0;
    end else if (ce) begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule : smsc_sync

// ### smsc_core.sv
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
module smsc_core #(
  parameter bit          IS_MASTER = 1'b1,
  parameter int unsigned WIDTH     = 8,
  parameter int unsigned NUM_SEL   = 1,
  parameter bit          LSB_FIRST = 1'b0,
  parameter bit          CPOL      = 1'b0,
  parameter bit          CPHA      = 1'b0,
  parameter int unsigned SCLK_HZ   = smsc_pkg::SCLK_HZ_DEFAULT
) (
  // clock, reset, enable
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       ce,
  // axi4-lite write
  input  wire logic [smsc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // axi4-lite read
  input  wire logic [smsc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // serial pins
  output logic                            sclk_o,
  input  wire logic                       sclk_i,
  output logic                            mosi_o,
  input  wire logic                       mosi_i,
  output logic                            miso_o,
  input  wire logic                       miso_i,
  input  wire logic                       ss_n_i,
  output logic [NUM_SEL-1:0]              indexed_target_select_line_n,
  // interrupt
  output logic                            irq
);

  // smallest even divisor whose rate does not exceed the target
  localparam int unsigned DIV  = ((smsc_pkg::SYS_CLK_HZ + 2 * SCLK_HZ - 1) / (2 * SCLK_HZ)) * 2;
  localparam int unsigned HALF = DIV / 2;
  localparam logic [smsc_pkg::DIV_W-1:0] HALF_LAST = smsc_pkg::DIV_W'(HALF - 1);
  localparam logic [smsc_pkg::CNT_W-1:0] EDGE_LAST = smsc_pkg::CNT_W'(2 * WIDTH - 1);
  localparam logic [smsc_pkg::CNT_W-1:0] BIT_LAST  = smsc_pkg::CNT_W'(WIDTH - 1);

  if (WIDTH < 1 || WIDTH > smsc_pkg::DATA_W_MAX) begin : g_bad_width
    $error("data width out of range");
  end
  if (NUM_SEL < 1 || NUM_SEL > smsc_pkg::SEL_W) begin : g_bad_sel
    $error("select line count out of range");
  end
  if (SCLK_HZ < 1 || HALF >= (1 << smsc_pkg::DIV_W)) begin : g_bad_rate
    $error("serial clock rate cannot be served");
  end

  function automatic logic [WIDTH-1:0] shift_in(input logic [WIDTH-1:0] r, input logic din);
    logic [WIDTH:0] t;
    t = LSB_FIRST ? {din, r} : {r, din};
    return LSB_FIRST ? t[WIDTH:1] : t[WIDTH-1:0];
  endfunction : shift_in

  function automatic logic [WIDTH-1:0] shift_out(input logic [WIDTH-1:0] r);
    logic [WIDTH:0] t;
    t = LSB_FIRST ? {1'b0, r} : {r, 1'b0};
    return LSB_FIRST ? t[WIDTH:1] : t[WIDTH-1:0];
  endfunction : shift_out

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (nw & m);
  endfunction : merge

  // pin inputs cross into the system clock before anything reads them
  logic [3:0] pin_q;
  smsc_sync #(.W(4)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    // idle levels travel as zero, so the reset value of the flops raises no false edge
    .d       ({sclk_i ^ CPOL, !ss_n_i, mosi_i, miso_i}),
    .q       (pin_q)
  );

  logic sclk_s;
  logic ss_s;
  logic mosi_s;
  logic miso_s;
  assign sclk_s = pin_q[3] ^ CPOL;
  assign ss_s   = !pin_q[2];
  assign mosi_s = pin_q[1];
  assign miso_s = pin_q[0];

  smsc_pkg::smsc_mstate_t      state;
  smsc_pkg::smsc_ctrl_t        ctrl;
  logic [smsc_pkg::SEL_W-1:0]  sel_reg;
  logic [smsc_pkg::DIV_W-1:0]  div_cnt;
  logic [smsc_pkg::CNT_W-1:0]  edge_cnt;
  logic [smsc_pkg::CNT_W-1:0]  bit_cnt;
  logic [WIDTH-1:0]            tx_hold;
  logic [WIDTH-1:0]            tx_shift;
  logic [WIDTH-1:0]            rx_hold;
  logic [WIDTH-1:0]            rx_shift;
  logic [WIDTH-1:0]            rx_next;
  logic                        tx_full;
  logic                        rrdy;
  logic                        overrun;
  logic                        started;
  logic                        sclk_q;
  logic                        sclk_d;
  logic                        active;
  logic                        edge_ev;
  logic                        is_lead;
  logic                        sample_ev;
  logic                        change_ev;
  logic                        word_done;
  logic                        shift_idle;
  logic                        load_ev;
  logic                        din;
  logic                        tx_bit;

  // serial edge events come from the divider as master, from the pin as slave
  always_comb begin
    if (IS_MASTER) begin
      active  = (state == smsc_pkg::MS_RUN);
      edge_ev = active && (div_cnt == HALF_LAST);
      is_lead = (sclk_q == CPOL);
    end else begin
      active  = !ss_s;
      edge_ev = active && (sclk_s != sclk_d);
      is_lead = (sclk_d == CPOL);
    end
  end

  // change edges before a word's first sample are skipped: the first bit is already on the pin
  assign sample_ev  = edge_ev && (is_lead ^ CPHA);
  assign change_ev  = edge_ev && !(is_lead ^ CPHA) && started;
  assign word_done  = sample_ev && (bit_cnt == BIT_LAST);
  assign shift_idle = IS_MASTER ? (state == smsc_pkg::MS_IDLE) : (!active || !started);
  assign load_ev    = shift_idle && tx_full;
  assign din        = IS_MASTER ? miso_s : mosi_s;
  assign rx_next    = shift_in(rx_shift, din);
  assign tx_bit     = LSB_FIRST ? tx_shift[0] : tx_shift[WIDTH-1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_d <= CPOL;
    end else if (ce) begin
      sclk_d <= sclk_s;
    end
  end

  // master sequencer and clock divider; a slave build never leaves idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= smsc_pkg::MS_IDLE;
      div_cnt  <= '0;
      edge_cnt <= '0;
      sclk_q   <= CPOL;
    end else if (ce && IS_MASTER) begin
      case (state)
        smsc_pkg::MS_IDLE: begin
          div_cnt  <= '0;
          edge_cnt <= '0;
          sclk_q   <= CPOL;
          if (tx_full) begin
            state <= smsc_pkg::MS_RUN;
          end
        end
        smsc_pkg::MS_RUN: begin
          if (div_cnt == HALF_LAST) begin
            div_cnt  <= '0;
            sclk_q   <= !sclk_q;
            edge_cnt <= edge_cnt + 1'b1;
            if (edge_cnt == EDGE_LAST) begin
              state <= smsc_pkg::MS_IDLE;
            end
          end else begin
            div_cnt <= div_cnt + 1'b1;
          end
        end
        default: begin
          state <= smsc_pkg::MS_IDLE;
        end
      endcase
    end
  end

  // word framing: bit count and whether the current word has begun
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_cnt <= '0;
      started <= 1'b0;
    end else if (ce) begin
      if (!active) begin
        bit_cnt <= '0;
        started <= 1'b0;
      end else if (sample_ev) begin
        bit_cnt <= word_done ? '0 : bit_cnt + 1'b1;
        started <= !word_done;
      end
    end
  end

  // transmit path: holding register double-buffers the shifter
  logic wr_go;
  logic wr_tx;
  logic [smsc_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  assign wr_tx = wr_go && (aw_addr == smsc_pkg::ADDR_TXDATA) && (w_strb != 4'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_hold  <= '0;
      tx_full  <= 1'b0;
      tx_shift <= '0;
    end else if (ce) begin
      if (wr_tx) begin
        tx_hold <= w_data[WIDTH-1:0];
      end
      // a write in the load cycle keeps the new word pending
      tx_full <= wr_tx || (tx_full && !load_ev);
      if (load_ev) begin
        tx_shift <= tx_hold;
      end else if (change_ev) begin
        tx_shift <= shift_out(tx_shift);
      end
    end
  end

  // receive path
  logic rd_go;
  logic rd_rx;
  assign rd_rx = rd_go && (s_axi_araddr == smsc_pkg::ADDR_RXDATA);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_shift <= '0;
      rx_hold  <= '0;
      rrdy     <= 1'b0;
      overrun  <= 1'b0;
    end else if (ce) begin
      if (sample_ev) begin
        rx_shift <= rx_next;
      end
      if (word_done) begin
        rx_hold <= rx_next;
      end
      // a completing word wins over a read in the same cycle
      rrdy <= word_done || (rrdy && !rd_rx);
      if (word_done && rrdy && !rd_rx) begin
        overrun <= 1'b1;
      end else if (wr_go && aw_addr == smsc_pkg::ADDR_STATUS) begin
        overrun <= 1'b0;
      end
    end
  end

  // axi4-lite write channel; flow control stalls a data write while the holding register is full
  logic aw_held;
  logic w_held;
  logic wr_stall;
  logic wr_mapped;
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign wr_stall  = ctrl.flow_en && (aw_addr == smsc_pkg::ADDR_TXDATA) && tx_full;
  assign wr_go     = aw_held && w_held && !s_axi_bvalid && !wr_stall;
  assign wr_mapped = (aw_addr == smsc_pkg::ADDR_RXDATA) || (aw_addr == smsc_pkg::ADDR_TXDATA) ||
                     (aw_addr == smsc_pkg::ADDR_STATUS) || (aw_addr == smsc_pkg::ADDR_CONTROL) ||
                     (aw_addr == smsc_pkg::ADDR_SELECT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= smsc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? smsc_pkg::RESP_OKAY : smsc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control and target-select registers
  logic [31:0] ctrl_new;
  logic [31:0] sel_new;
  assign ctrl_new = merge({29'h0000_0000, ctrl}, w_data, w_strb);
  assign sel_new  = merge({16'h0000, sel_reg}, w_data, w_strb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl    <= smsc_pkg::CTRL_RESET;
      sel_reg <= smsc_pkg::SELECT_RESET;
    end else if (ce && wr_go) begin
      if (aw_addr == smsc_pkg::ADDR_CONTROL) begin
        ctrl <= ctrl_new[2:0];
      end
      if (aw_addr == smsc_pkg::ADDR_SELECT) begin
        sel_reg <= sel_new[15:0];
      end
    end
  end

  // axi4-lite read channel; flow control holds off a data read until a word is ready
  smsc_pkg::smsc_status_t status;
  logic rd_stall;
  assign status.overrun = overrun;
  assign status.busy    = active;
  assign status.tmt     = !tx_full && shift_idle;
  assign status.trdy    = !tx_full;
  assign status.rrdy    = rrdy;
  assign rd_stall      = ctrl.flow_en && (s_axi_araddr == smsc_pkg::ADDR_RXDATA) && !rrdy;
  assign s_axi_arready = !s_axi_rvalid && !rd_stall;
  assign rd_go         = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= smsc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= smsc_pkg::RESP_OKAY;
        case (s_axi_araddr)
          smsc_pkg::ADDR_RXDATA:  s_axi_rdata <= 32'(rx_hold);
          smsc_pkg::ADDR_TXDATA:  s_axi_rdata <= 32'(tx_hold);
          smsc_pkg::ADDR_STATUS:  s_axi_rdata <= 32'(status);
          smsc_pkg::ADDR_CONTROL: s_axi_rdata <= 32'(ctrl);
          smsc_pkg::ADDR_SELECT:  s_axi_rdata <= 32'(sel_reg);
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= smsc_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // pins: a slave drives miso at all times, an outside buffer must isolate it
  assign sclk_o = IS_MASTER ? sclk_q : CPOL;
  assign mosi_o = IS_MASTER ? tx_bit : 1'b0;
  assign miso_o = IS_MASTER ? 1'b0 : tx_bit;
  assign irq    = (rrdy && ctrl.irq_rx_en) || (!tx_full && ctrl.irq_tx_en);

  for (genvar i = 0; i < NUM_SEL; i++) begin : g_sel
    assign indexed_target_select_line_n[i] = !(IS_MASTER && active && sel_reg[i]);
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  sequence s_tx_write;
    IS_MASTER && wr_tx && state == smsc_pkg::MS_IDLE && !tx_full;
  endsequence

  sequence s_run_start;
    ##2 (state == smsc_pkg::MS_RUN && tx_shift == $past(w_data[WIDTH-1:0], 2));
  endsequence

  a_mode_fixed: assert property (!IS_MASTER |-> state == smsc_pkg::MS_IDLE && sclk_o == CPOL && (&indexed_target_select_line_n))
    else $error("slave build left idle or drove master pins");
  a_launch_write: assert property (s_tx_write |-> s_run_start)
    else $error("transmit write did not launch a transfer");
  a_tx_load: assert property (load_ev && !wr_tx |=> tx_shift == $past(tx_hold) && !tx_full)
    else $error("idle shifter not loaded from holding register");
  a_rx_copy: assert property (word_done |=> rrdy && rx_hold == $past(rx_next))
    else $error("completed word not copied to receive holding");
  a_idle_pins: assert property (IS_MASTER && state == smsc_pkg::MS_IDLE |-> sclk_o == CPOL && (&indexed_target_select_line_n))
    else $error("idle master drives select or sclk");
  a_sclk_div: assert property (IS_MASTER && $changed(sclk_o) |-> $past(div_cnt) == HALF_LAST && $past(active))
    else $error("sclk toggled off the divider period");
  a_sel_target: assert property (IS_MASTER && active |-> indexed_target_select_line_n == ~sel_reg[NUM_SEL-1:0])
    else $error("select lines do not follow target register");
  a_flow_hold: assert property ($rose(s_axi_bvalid) && $past(ctrl.flow_en) && $past(aw_addr) == smsc_pkg::ADDR_TXDATA
                                |-> !$past(tx_full))
    else $error("flow-controlled write taken while holding register full");
  a_status_poll: assert property (rd_go && s_axi_araddr == smsc_pkg::ADDR_STATUS |=> s_axi_rdata[0] == $past(rrdy)
                                  && s_axi_rdata[1] == $past(!tx_full))
    else $error("status read does not show progress flags");
  a_irq_rx: assert property (rrdy && ctrl.irq_rx_en |-> irq)
    else $error("receive ready did not raise interrupt");
  a_slave_start: assert property (!IS_MASTER && $fell(ss_s) |-> active && bit_cnt == '0)
    else $error("slave did not start on select");

endmodule : smsc_core

// ### smsc_slave_model.sv
module smsc_slave_model #(
  parameter int unsigned W = 8
) (
  // serial pins
  input  wire logic         sclk,
  input  wire logic         ss_n,
  input  wire logic         mosi,
  output logic              miso,
  // bench side
  input  wire logic [W-1:0] seed,
  output logic [W-1:0]      rx_word,
  output logic              rx_tgl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0] sh;
  logic [W-1:0] rx;
  logic         seen;
  int           cnt;
  initial begin
    miso = 1'b1;
    rx_tgl = 1'b0;
    seen = 1'b0;
  end
  // replies with the last word heard, so back-to-back words need no bench timing
  always @(negedge ss_n) begin
    sh = seen ? rx_word : seed;
    miso = sh[W-1];
    cnt = 0;
  end
  always @(posedge sclk) if (!ss_n) begin
    rx = {rx[W-2:0], mosi};
    cnt++;
    if (cnt == W) begin
      rx_word = rx;
      seen = 1'b1;
      rx_tgl = ~rx_tgl;
    end
  end
  always @(negedge sclk) if (!ss_n) begin
    sh = sh << 1;
    miso = sh[W-1];
  end
  // no pull on the line: a released driver shows a wrong level, never the last bit
  always @(posedge ss_n) miso = ~miso;
endmodule : smsc_slave_model

// ### spi_master_slave_core_tb_top.sv
module spi_master_slave_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned W = 8;
  logic         aclk = 1'b0;
  logic         aresetn = 1'b0;
  logic         one = 1'b1;
  logic         zero = 1'b0;
  logic [4:0]   awaddr, araddr;
  logic         awvalid, wvalid, bready, arvalid, rready;
  logic [31:0]  wdata, rdata;
  logic [3:0]   wstrb = 4'hF;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [1:0]   bresp, rresp, sel;
  logic         sclk, mosi, miso, irq, rx_tgl;
  logic         slv_miso, m_in;
  logic [W-1:0] seed, rx_word, a, b, c, e_m;
  logic [33:0]  e_b, e_r;
  logic [1:0]   exp_b[$];
  logic [33:0]  exp_r[$];
  logic [W-1:0] exp_m[$];
  int           error_cnt = 0;
  int           compares = 0;
  int           nclk = 0;
  longint       per = 0;
  longint       tl = 0;

  smsc_core #(.IS_MASTER(1'b1), .WIDTH(W), .NUM_SEL(2), .SCLK_HZ(5_000_000)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(one),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sclk_o(sclk), .sclk_i(zero), .mosi_o(mosi), .mosi_i(zero), .miso_o(), .miso_i(m_in),
    .ss_n_i(one), .indexed_target_select_line_n(sel), .irq(irq));
  // a slave build on select line 1 answers the master; only one answering slave is selected
  smsc_core #(.IS_MASTER(1'b0), .WIDTH(W)) u_dut_slv (
    .aclk(aclk), .aresetn(aresetn), .ce(one),
    .s_axi_awaddr('0), .s_axi_awvalid(zero), .s_axi_awready(),
    .s_axi_wdata('0), .s_axi_wstrb('0), .s_axi_wvalid(zero), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(one),
    .s_axi_araddr('0), .s_axi_arvalid(zero), .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(one),
    .sclk_o(), .sclk_i(sclk), .mosi_o(), .mosi_i(mosi), .miso_o(slv_miso), .miso_i(zero),
    .ss_n_i(sel[1]), .indexed_target_select_line_n(), .irq());
  assign m_in = sel[0] ? slv_miso : miso;
  smsc_slave_model #(.W(W)) u_peer (.sclk(sclk), .ss_n(sel[0]), .mosi(mosi), .miso(miso),
    .seed(seed), .rx_word(rx_word), .rx_tgl(rx_tgl));

  initial begin
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge sclk) begin
    nclk++;
    per = $time - tl;
    tl = $time;
  end

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic tmo();
    error_cnt++;
    $display("MISMATCH wait expected answer seen timeout");
    conclude();
  endtask : tmo

  // handshakes are judged at the falling edge, which sees what the next rise samples
  task automatic axw(input logic [4:0] ad, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic ta, tw, tb;
    exp_b.push_back(r);
    @(posedge aclk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) break;
    end
    bready <= 1'b0;
    if (n == 400) tmo();
  endtask : axw

  task automatic axr(input logic [4:0] ad, input logic [33:0] x);
    int n;
    logic ta, tr;
    exp_r.push_back(x);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) break;
    end
    rready <= 1'b0;
    if (n == 400) tmo();
  endtask : axr

  task automatic wsel(input logic [1:0] v);
    int n;
    for (n = 0; n < 400 && sel !== v; n++) @(negedge aclk);
    if (n == 400) tmo();
  endtask : wsel

  always @(negedge aclk) begin
    if (bvalid && bready) begin
      e_b = exp_b.size() ? {32'h0, exp_b.pop_front()} : 'x;
      chk("bresp", e_b, {32'h0, bresp});
    end
    if (rvalid && rready) begin
      e_r = exp_r.size() ? exp_r.pop_front() : 'x;
      chk("read", e_r, {rresp, rdata});
    end
  end
  always @(rx_tgl) if ($time > 0) begin
    e_m = exp_m.size() ? exp_m.pop_front() : 'x;
    chk("peer rx", {26'h0, e_m}, {26'h0, rx_word});
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0000_0000;
    seed = '0;
    void'($urandom(63116));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axr(smsc_pkg::ADDR_STATUS, 34'h0_0000_0006);
    axr(smsc_pkg::ADDR_CONTROL, 34'h0);
    axr(smsc_pkg::ADDR_SELECT, 34'h0);
    chk("idle pins", 34'h0_0000_0006, {30'h0, sclk, sel, irq});
    for (int i = 0; i < 3; i++) begin
      axw(5'(5'h14 + 4 * i), 32'hFFFF_FFFF, smsc_pkg::RESP_SLVERR);
      axr(5'(5'h14 + 4 * i), 34'h2_0000_0000);
    end
    $display("test reset and map done");
    axw(smsc_pkg::ADDR_SELECT, 32'h0000_0001, smsc_pkg::RESP_OKAY);
    axw(smsc_pkg::ADDR_CONTROL, 32'h0000_0002, smsc_pkg::RESP_OKAY);
    @(negedge aclk);
    chk("irq tx", 34'h1, 34'(irq));
    axw(smsc_pkg::ADDR_CONTROL, 32'h0000_0001, smsc_pkg::RESP_OKAY);
    @(negedge aclk);
    chk("irq masked", 34'h0, 34'(irq));
    a = W'($urandom);
    c = W'($urandom);
    seed <= c;
    exp_m.push_back(a);
    nclk = 0;
    axw(smsc_pkg::ADDR_TXDATA, {24'h0, a}, smsc_pkg::RESP_OKAY);
    wsel(2'b10);
    wsel(2'b11);
    chk("sclk edges", 34'h0_0000_0008, 34'(nclk));
    chk("sclk period", 34'h0_0000_00C8, 34'(per));
    chk("sclk idle", 34'h0, 34'(sclk));
    chk("irq rx", 34'h1, 34'(irq));
    axr(smsc_pkg::ADDR_RXDATA, {26'h0, c});
    @(negedge aclk);
    chk("irq cleared", 34'h0, 34'(irq));
    $display("test single word done");
    b = W'($urandom);
    c = W'($urandom);
    exp_m.push_back(b);
    exp_m.push_back(c);
    axw(smsc_pkg::ADDR_CONTROL, 32'h0000_0004, smsc_pkg::RESP_OKAY);
    axw(smsc_pkg::ADDR_TXDATA, {24'h0, b}, smsc_pkg::RESP_OKAY);
    axw(smsc_pkg::ADDR_TXDATA, {24'h0, c}, smsc_pkg::RESP_OKAY);
    axr(smsc_pkg::ADDR_RXDATA, {26'h0, a});
    axr(smsc_pkg::ADDR_RXDATA, {26'h0, b});
    wsel(2'b11);
    axr(smsc_pkg::ADDR_STATUS, 34'h0_0000_0006);
    $display("test back to back done");
    c = W'($urandom);
    axw(smsc_pkg::ADDR_SELECT, 32'h0000_0002, smsc_pkg::RESP_OKAY);
    axw(smsc_pkg::ADDR_TXDATA, {24'h0, c}, smsc_pkg::RESP_OKAY);
    wsel(2'b01);
    wsel(2'b11);
    axr(smsc_pkg::ADDR_RXDATA, 34'h0);
    chk("pending", 34'h0, 34'(exp_b.size() + exp_r.size() + exp_m.size()));
    $display("test slave build done");
    conclude();
  end
endmodule : spi_master_slave_core_tb_top
